// ---- hw/accr_cfg.svh ----
// constants for the two-channel calibration and configuration register bank
// assumes an apb slave on pclk; byte address = 4 * register index
//
// Overview of operation
// - upper offset register holds offset bits 23:8 in all 16 bits.
// - lower offset bits 15:8 hold offset bits 7:0; bits 7:0 read zero.
// - upper gain register holds gain bits 23:8 in all 16 bits.
// - lower gain bits 15:8 hold gain bits 7:0; bits 7:0 read zero.
// - upper gain registers reset to 8000h, lower gain registers to zero.
// - upper and lower offset registers of every channel reset to zero.
// - registers decode at indexes ah, bh, ch, dh, eh, fh, 10h and 11h.
// - channel 1 phase delay is config 15:6, signed 10 bits, reset zero.
// - config bit 2 set bypasses dc blocking for channel 1 only.
// - config 1:0 pick pins, shorted inputs, positive or negative test.
// - global 4-bit dc coefficient: zero disables, else 1/4 halving.
`ifndef ACCR_CFG_SVH
`define ACCR_CFG_SVH

`define ACCR_IDX_C0_OCAL_UP 8'h0a
`define ACCR_IDX_C0_OCAL_LO 8'h0b
`define ACCR_IDX_C0_GCAL_UP 8'h0c
`define ACCR_IDX_C0_GCAL_LO 8'h0d
`define ACCR_IDX_C1_CFG 8'h0e
`define ACCR_IDX_C1_OCAL_UP 8'h0f
`define ACCR_IDX_C1_OCAL_LO 8'h10
`define ACCR_IDX_DCBLK 8'h11

`define ACCR_RST_OCAL_UP 16'h0000
`define ACCR_RST_GCAL_UP 16'h8000
`define ACCR_RST_LO 8'h00
`define ACCR_RST_CFG 16'h0000
`define ACCR_RST_DCBLK 4'h0

`define ACCR_CFG_PHASE_MSB 15
`define ACCR_CFG_PHASE_LSB 6
`define ACCR_CFG_BYPASS_BIT 2
`define ACCR_CFG_MUX_MSB 1
`define ACCR_CFG_MUX_LSB 0
`define ACCR_CFG_WR_MASK 16'hffc7

`endif

// ---- hw/accr_pkg.sv ----
// types for the calibration register bank
// assumes nothing beyond the configuration header
package accr_pkg;
    typedef enum logic [1:0] {
        ACCR_MUX_PINS,
        ACCR_MUX_SHORT,
        ACCR_MUX_TEST_POS,
        ACCR_MUX_TEST_NEG
    } accr_mux_t;

    typedef enum logic [1:0] {
        ACCR_APB_IDLE,
        ACCR_APB_ACCESS
    } accr_apb_state_t;
endpackage : accr_pkg

// ---- hw/accr_wr_if.sv ----
// write/read strobe bundle from the apb front end to the register store
// assumes a single pclk domain
`timescale 1ns/1ps
`default_nettype none
interface accr_wr_if;
    logic wr_en;
    logic [7:0] idx;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic hit;
    modport front (output wr_en, output idx, output wdata,
                   input rdata, input hit);
    modport store (input wr_en, input idx, input wdata,
                   output rdata, output hit);
endinterface : accr_wr_if
`default_nettype wire

// ---- hw/accr_apb_slave.sv ----
// apb slave front end: decodes one word per register, answers in 2 cycles
// assumes 32-bit apb on pclk, registers decoded by the store
`timescale 1ns/1ps
`default_nettype none
module accr_apb_slave (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // register store
    accr_wr_if.front rf
);
    import accr_pkg::*;

    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic aligned;

    assign aligned = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h0);
    assign rf.idx = paddr[9:2];
    assign rf.wdata = pwdata[15:0];
    // write lands at the completing edge only
    assign rf.wr_en = clk_en && psel && penable && pwrite && pready_q
                      && aligned && rf.hit;

    // one wait state, then pready for exactly one cycle
    always_comb begin
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        if (psel && penable && !pready_q) begin
            pready_d = 1'b1;
            pslverr_d = !(aligned && rf.hit);
            prdata_d = (aligned && rf.hit && !pwrite)
                       ? {16'h0000, rf.rdata} : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (clk_en) begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;
endmodule : accr_apb_slave
`default_nettype wire

// ---- hw/accr_regs.sv ----
// register store: calibration words, channel 1 config, global dc coefficient
// assumes strobes from the apb front end on the same clock
`include "accr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module accr_regs (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // front end
    accr_wr_if.store rf,
    // stored values
    output logic [23:0] c0_offset,
    output logic [23:0] c0_gain,
    output logic [23:0] c1_offset,
    output logic [15:0] c1_cfg,
    output logic [3:0] dc_coeff
);
    import accr_pkg::*;

    logic [15:0] c0_ou_q, c0_ou_d, c0_gu_q, c0_gu_d, c1_ou_q, c1_ou_d;
    logic [7:0] c0_ol_q, c0_ol_d, c0_gl_q, c0_gl_d, c1_ol_q, c1_ol_d;
    logic [15:0] cfg_q, cfg_d;
    logic [3:0] dcb_q, dcb_d;

    function automatic logic wr_at(input logic [7:0] idx);
        wr_at = rf.wr_en && (rf.idx == idx);
    endfunction : wr_at

    always_comb begin
        c0_ou_d = wr_at(`ACCR_IDX_C0_OCAL_UP) ? rf.wdata : c0_ou_q;
        c1_ou_d = wr_at(`ACCR_IDX_C1_OCAL_UP) ? rf.wdata : c1_ou_q;
        c0_gu_d = wr_at(`ACCR_IDX_C0_GCAL_UP) ? rf.wdata : c0_gu_q;
        c0_ol_d = wr_at(`ACCR_IDX_C0_OCAL_LO)
                  ? rf.wdata[15:8] : c0_ol_q;
        c1_ol_d = wr_at(`ACCR_IDX_C1_OCAL_LO)
                  ? rf.wdata[15:8] : c1_ol_q;
        c0_gl_d = wr_at(`ACCR_IDX_C0_GCAL_LO)
                  ? rf.wdata[15:8] : c0_gl_q;
        // read-only bits 5:3 never take write data
        cfg_d = wr_at(`ACCR_IDX_C1_CFG)
                ? (rf.wdata & `ACCR_CFG_WR_MASK) : cfg_q;
        dcb_d = wr_at(`ACCR_IDX_DCBLK) ? rf.wdata[3:0] : dcb_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c0_ou_q <= `ACCR_RST_OCAL_UP;
            c1_ou_q <= `ACCR_RST_OCAL_UP;
            c0_ol_q <= `ACCR_RST_LO;
            c1_ol_q <= `ACCR_RST_LO;
            c0_gu_q <= `ACCR_RST_GCAL_UP;
            c0_gl_q <= `ACCR_RST_LO;
            cfg_q <= `ACCR_RST_CFG;
            dcb_q <= `ACCR_RST_DCBLK;
        end else if (clk_en) begin
            c0_ou_q <= c0_ou_d;
            c1_ou_q <= c1_ou_d;
            c0_ol_q <= c0_ol_d;
            c1_ol_q <= c1_ol_d;
            c0_gu_q <= c0_gu_d;
            c0_gl_q <= c0_gl_d;
            cfg_q <= cfg_d;
            dcb_q <= dcb_d;
        end
    end

    // read mux; low bytes of lower words read zero
    always_comb begin
        rf.hit = 1'b1;
        case (rf.idx)
            `ACCR_IDX_C0_OCAL_UP: rf.rdata = c0_ou_q;
            `ACCR_IDX_C0_OCAL_LO: rf.rdata = {c0_ol_q, 8'h00};
            `ACCR_IDX_C0_GCAL_UP: rf.rdata = c0_gu_q;
            `ACCR_IDX_C0_GCAL_LO: rf.rdata = {c0_gl_q, 8'h00};
            `ACCR_IDX_C1_CFG: rf.rdata = cfg_q;
            `ACCR_IDX_C1_OCAL_UP: rf.rdata = c1_ou_q;
            `ACCR_IDX_C1_OCAL_LO: rf.rdata = {c1_ol_q, 8'h00};
            `ACCR_IDX_DCBLK: rf.rdata = {12'h000, dcb_q};
            default: begin
                rf.rdata = 16'h0000;
                rf.hit = 1'b0;
            end
        endcase
    end

    assign c0_offset = {c0_ou_q, c0_ol_q};
    assign c0_gain = {c0_gu_q, c0_gl_q};
    assign c1_offset = {c1_ou_q, c1_ol_q};
    assign c1_cfg = cfg_q;
    assign dc_coeff = dcb_q;

    property p_cfg_ro;
        @(posedge pclk) disable iff (!presetn)
        cfg_q[5:3] == 3'h0;
    endproperty
    a_cfg_ro: assert property (p_cfg_ro)
        else $error("config read-only bits set");
    property p_lo_zero;
        @(posedge pclk) disable iff (!presetn)
        (rf.idx == `ACCR_IDX_C0_GCAL_LO) |-> rf.rdata[7:0] == 8'h00;
    endproperty
    a_lo_zero: assert property (p_lo_zero)
        else $error("gain lower low byte not zero");
endmodule : accr_regs
`default_nettype wire

// ---- hw/accr_top.sv ----
// top of the calibration and configuration register bank
// assumes apb master on pclk; outputs feed the conversion datapath
//
// The APB register port was left to the implementer.
`include "accr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module accr_top (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // channel 0 calibration
    output logic [23:0] chan0_offset_word,
    output logic [23:0] chan0_gain_word,
    // channel 1 calibration and config
    output logic [23:0] chan1_offset_word,
    output logic signed [9:0] chan1_phase_delay,
    output logic chan1_dc_block_bypass,
    output var accr_pkg::accr_mux_t chan1_input_select,
    output logic chan1_dc_block_active,
    output logic [3:0] global_dc_block_coeff,
    output logic [4:0] chan1_dc_block_shift,
    // unity-gain status
    output logic chan0_gain_unity
);
    import accr_pkg::*;

    accr_wr_if rf ();
    logic [23:0] c0_off, c0_gain, c1_off;
    logic [15:0] cfg;
    logic [3:0] dcb;

    logic [23:0] c0_off_q, c0_off_d, c0_gain_q, c0_gain_d, c1_off_q, c1_off_d;
    logic [9:0] phase_q, phase_d;
    logic byp_q, byp_d, act_q, act_d, unity_q, unity_d;
    accr_mux_t mux_q, mux_d;
    logic [3:0] dcb_q, dcb_d;
    logic [4:0] shift_q, shift_d;

    accr_apb_slave u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pready(pready),
        .pslverr(pslverr),
        .prdata(prdata),
        .rf(rf)
    );

    accr_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .rf(rf),
        .c0_offset(c0_off),
        .c0_gain(c0_gain),
        .c1_offset(c1_off),
        .c1_cfg(cfg),
        .dc_coeff(dcb)
    );

    // output stage: every datapath control comes from a flop
    always_comb begin
        c0_off_d = c0_off;
        c0_gain_d = c0_gain;
        c1_off_d = c1_off;
        phase_d = cfg[`ACCR_CFG_PHASE_MSB:`ACCR_CFG_PHASE_LSB];
        byp_d = cfg[`ACCR_CFG_BYPASS_BIT];
        mux_d = accr_mux_t'(
            cfg[`ACCR_CFG_MUX_MSB:`ACCR_CFG_MUX_LSB]);
        dcb_d = dcb;
        // zero coefficient disables the filter everywhere
        act_d = !cfg[`ACCR_CFG_BYPASS_BIT] && (dcb != 4'h0);
        // coefficient 1/4 at code 1 is a shift of 2, halving per step
        shift_d = (dcb == 4'h0) ? 5'h00 : 5'({1'b0, dcb} + 5'h01);
        unity_d = (c0_gain == {`ACCR_RST_GCAL_UP, `ACCR_RST_LO});
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c0_off_q <= 24'h000000;
            c0_gain_q <= {`ACCR_RST_GCAL_UP, `ACCR_RST_LO};
            c1_off_q <= 24'h000000;
            phase_q <= 10'h000;
            byp_q <= 1'b0;
            mux_q <= ACCR_MUX_PINS;
            dcb_q <= `ACCR_RST_DCBLK;
            act_q <= 1'b0;
            shift_q <= 5'h00;
            unity_q <= 1'b1;
        end else if (clk_en) begin
            c0_off_q <= c0_off_d;
            c0_gain_q <= c0_gain_d;
            c1_off_q <= c1_off_d;
            phase_q <= phase_d;
            byp_q <= byp_d;
            mux_q <= mux_d;
            dcb_q <= dcb_d;
            act_q <= act_d;
            shift_q <= shift_d;
            unity_q <= unity_d;
        end
    end

    assign chan0_offset_word = c0_off_q;
    assign chan0_gain_word = c0_gain_q;
    assign chan1_offset_word = c1_off_q;
    assign chan1_phase_delay = phase_q;
    assign chan1_dc_block_bypass = byp_q;
    assign chan1_input_select = mux_q;
    assign global_dc_block_coeff = dcb_q;
    assign chan1_dc_block_active = act_q;
    assign chan1_dc_block_shift = shift_q;
    assign chan0_gain_unity = unity_q;

    // a write to an upper or lower word is visible at the output two edges later
    property p_ocal_up;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && rf.wr_en && rf.idx == `ACCR_IDX_C0_OCAL_UP) ##1 clk_en
        |=> chan0_offset_word[23:8] == $past(rf.wdata, 2);
    endproperty
    a_ocal_up: assert property (p_ocal_up)
        else $error("offset upper lost");
    property p_gcal_lo;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && rf.wr_en && rf.idx == `ACCR_IDX_C0_GCAL_LO) ##1 clk_en
        |=> chan0_gain_word[7:0] == $past(rf.wdata[15:8], 2);
    endproperty
    a_gcal_lo: assert property (p_gcal_lo)
        else $error("gain lower lost");
    property p_gcal_up;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && rf.wr_en && rf.idx == `ACCR_IDX_C0_GCAL_UP) ##1 clk_en
        |=> chan0_gain_word[23:8] == $past(rf.wdata, 2);
    endproperty
    a_gcal_up: assert property (p_gcal_up)
        else $error("gain upper lost");
    property p_lo_read;
        @(posedge pclk) disable iff (!presetn)
        (pready && !pslverr && !pwrite && paddr[9:2] == `ACCR_IDX_C1_OCAL_LO)
        |-> prdata[7:0] == 8'h00;
    endproperty
    a_lo_read: assert property (p_lo_read)
        else $error("low byte not zero");
    property p_rst_gain;
        @(posedge pclk) $rose(presetn) |-> chan0_gain_word == 24'h800000
            && chan0_offset_word == 24'h000000;
    endproperty
    a_rst_gain: assert property (p_rst_gain)
        else $error("bad reset");
    property p_decode;
        @(posedge pclk) disable iff (!presetn)
        (pready && paddr[1:0] == 2'h0 && paddr[31:10] == 22'h0
         && paddr[9:2] > `ACCR_IDX_DCBLK) |-> pslverr;
    endproperty
    a_decode: assert property (p_decode)
        else $error("unmapped accepted");
    property p_phase;
        @(posedge pclk) disable iff (!presetn)
        clk_en |=> chan1_phase_delay == $past(cfg[15:6]);
    endproperty
    a_phase: assert property (p_phase) else $error("phase mismatch");
    property p_bypass;
        @(posedge pclk) disable iff (!presetn)
        chan1_dc_block_bypass |-> !chan1_dc_block_active;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass ignored");
    property p_mux;
        @(posedge pclk) disable iff (!presetn)
        clk_en |=> chan1_input_select == accr_mux_t'($past(cfg[1:0]));
    endproperty
    a_mux: assert property (p_mux) else $error("mux mismatch");
    property p_coeff;
        @(posedge pclk) disable iff (!presetn)
        (global_dc_block_coeff == 4'h0) |-> !chan1_dc_block_active;
    endproperty
    a_coeff: assert property (p_coeff)
        else $error("zero code active");
    property p_unity;
        @(posedge pclk) disable iff (!presetn)
        clk_en |=> chan0_gain_unity == ($past(c0_gain) == 24'h800000);
    endproperty
    a_unity: assert property (p_unity)
        else $error("unity flag wrong");

    c_wr: cover property (@(posedge pclk) pready && pwrite && !pslverr);
    c_rd: cover property (@(posedge pclk) pready && !pwrite && !pslverr);
    c_err: cover property (@(posedge pclk) pready && pslverr);
    c_byp: cover property (@(posedge pclk) chan1_dc_block_bypass);
endmodule : accr_top
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the calibration register bank, apb stimulus
// assumes accr_top on pclk with an apb slave that answers on its own time
`timescale 1ns/1ps
`default_nettype none
`include "accr_cfg.svh"
module tb_top;
    import accr_pkg::*;
    logic pclk;
    logic presetn;
    logic clk_en;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [23:0] c0_off;
    logic [23:0] c0_gain;
    logic [23:0] c1_off;
    logic signed [9:0] c1_phase;
    logic c1_bypass;
    accr_mux_t c1_sel;
    logic c1_active;
    logic [3:0] dc_coeff;
    logic [4:0] dc_shift;
    logic c0_unity;
    int mismatches;
    int samples_checked;
    logic [31:0] rd;
    logic err;
    bit busy;
    logic [7:0] idx_tab [7];
    logic [15:0] rst_tab [7];
    logic [15:0] msk_tab [7];
    logic [15:0] val_tab [7];
    logic [3:0] cf_tab [3];
    logic [31:0] bad_tab [4];

    accr_top u_dut (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata),
        .chan0_offset_word(c0_off), .chan0_gain_word(c0_gain),
        .chan1_offset_word(c1_off), .chan1_phase_delay(c1_phase),
        .chan1_dc_block_bypass(c1_bypass), .chan1_input_select(c1_sel),
        .chan1_dc_block_active(c1_active),
        .global_dc_block_coeff(dc_coeff),
        .chan1_dc_block_shift(dc_shift), .chan0_gain_unity(c0_unity)
    );

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task end_sim;
        $display("mismatches=%0d samples_checked=%0d", mismatches,
                 samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    task chk(input string name, input logic [31:0] exp,
             input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // keep leaves psel up so the next setup follows at once
    task apb(input logic wr, input logic [31:0] addr,
             input logic [31:0] wd, input bit keep);
        int n;
        if (!busy) @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        n = 0;
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (pready !== 1'b1) begin
            mismatches++;
            $display("Error pready expected 1 seen timeout");
            end_sim;
        end
        rd = prdata;
        err = pslverr;
        busy = keep;
        if (!keep) begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    // upper pwdata half is junk on purpose: it must be ignored
    task wr16(input logic [7:0] idx, input logic [15:0] v, input bit keep);
        apb(1'b1, {22'h0, idx, 2'b00}, {16'hc3a5, v}, keep);
    endtask : wr16

    task rd_chk(input string name, input logic [7:0] idx,
                input logic [15:0] exp, input bit keep);
        apb(1'b0, {22'h0, idx, 2'b00}, 32'h0, keep);
        chk(name, {16'h0, exp}, rd);
        chk("pslverr", 32'h0, {31'h0, err});
    endtask : rd_chk

    // every datapath output and every register except the dc coefficient at its reset value
    task rst_chk;
        chk("c0_gain", 32'h800000, {8'h0, c0_gain});
        chk("c0_unity", 32'h1, {31'h0, c0_unity});
        chk("c0_off", 32'h0, {8'h0, c0_off});
        chk("c1_off", 32'h0, {8'h0, c1_off});
        chk("c1_cfg", 32'h0, {19'h0, c1_phase, c1_bypass, c1_sel});
        chk("dc_out", 32'h0, {22'h0, c1_active, dc_coeff, dc_shift});
        for (int i = 0; i < 7; i++) begin
            rd_chk("reset_val", idx_tab[i], rst_tab[i], 1'b0);
        end
    endtask : rst_chk

    initial begin
        repeat (100000) @(posedge pclk);
        mismatches++;
        $display("Error run expected done seen timeout");
        end_sim;
    end

    initial begin
        presetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        busy = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        idx_tab = '{`ACCR_IDX_C0_OCAL_UP, `ACCR_IDX_C0_OCAL_LO,
                    `ACCR_IDX_C0_GCAL_UP, `ACCR_IDX_C0_GCAL_LO,
                    `ACCR_IDX_C1_CFG, `ACCR_IDX_C1_OCAL_UP,
                    `ACCR_IDX_C1_OCAL_LO};
        rst_tab = '{16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000,
                    16'h0000, 16'h0000};
        msk_tab = '{16'hffff, 16'hff00, 16'hffff, 16'hff00, 16'hffc7,
                    16'hffff, 16'hff00};
        val_tab = '{16'h1234, 16'habff, 16'h8001, 16'h7f5a, 16'h827f,
                    16'hfedc, 16'h65a3};
        cf_tab = '{4'h0, 4'h1, 4'hf};
        bad_tab = '{32'h24, 32'h48, 32'h2a, 32'h428};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rst_chk;
        // back-to-back writes then reads catch aliasing in the decode
        for (int i = 0; i < 7; i++) begin
            wr16(idx_tab[i], val_tab[i], i < 6);
        end
        for (int i = 0; i < 7; i++) begin
            rd_chk("readback", idx_tab[i], val_tab[i] & msk_tab[i],
                   i < 6);
        end
        chk("c0_off_w", {8'h0, val_tab[0], val_tab[1][15:8]},
            {8'h0, c0_off});
        chk("c0_gain_w", {8'h0, val_tab[2], val_tab[3][15:8]},
            {8'h0, c0_gain});
        chk("c1_off_w", {8'h0, val_tab[5], val_tab[6][15:8]},
            {8'h0, c1_off});
        chk("c1_phase", {22'h0, val_tab[4][15:6]}, {22'h0, c1_phase});
        chk("c0_unity", 32'h0, {31'h0, c0_unity});
        wr16(`ACCR_IDX_C0_GCAL_LO, 16'h0000, 1'b0);
        wr16(`ACCR_IDX_C0_GCAL_UP, 16'h8000, 1'b0);
        repeat (3) @(posedge pclk);
        chk("c0_unity", 32'h1, {31'h0, c0_unity});
        for (int c = 0; c < 3; c++) begin
            for (int b = 0; b < 2; b++) begin
                for (int m = 0; m < 4; m++) begin
                    wr16(`ACCR_IDX_DCBLK, {12'h0, cf_tab[c]}, 1'b1);
                    wr16(`ACCR_IDX_C1_CFG, {10'h1ff, 3'b0, b[0], m[1:0]},
                         1'b0);
                    repeat (3) @(posedge pclk);
                    chk("c1_sel", m, {30'h0, c1_sel});
                    chk("c1_bypass", b, {31'h0, c1_bypass});
                    chk("c1_phase", 32'h1ff, {22'h0, c1_phase});
                    chk("dc_coeff", {28'h0, cf_tab[c]},
                        {28'h0, dc_coeff});
                    chk("c1_active", {31'h0, b == 0 && cf_tab[c] != 0},
                        {31'h0, c1_active});
                    chk("dc_shift", cf_tab[c] == 0 ? 32'h0 : cf_tab[c] + 32'h1,
                        {27'h0, dc_shift});
                end
            end
        end
        // misaligned 2ah would hit the channel 0 upper offset if decoded
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, bad_tab[i], 32'h0000ffff, 1'b0);
            chk("wr_err", 32'h1, {31'h0, err});
            apb(1'b0, bad_tab[i], 32'h0, 1'b0);
            chk("rd_err", 32'h1, {31'h0, err});
            chk("rd_bad", 32'h0, rd);
        end
        rd_chk("untouched", `ACCR_IDX_C0_OCAL_UP, val_tab[0], 1'b0);
        // mid-run reset must undo every write
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rst_chk;
        // frozen enable stalls the answer; the write lands once it returns
        clk_en <= 1'b0;
        fork
            wr16(`ACCR_IDX_C1_OCAL_UP, 16'h5a5a, 1'b0);
            begin
                repeat (6) @(posedge pclk);
                chk("frozen_pready", 32'h0, {31'h0, pready});
                clk_en <= 1'b1;
            end
        join
        repeat (3) @(posedge pclk);
        chk("c1_off_frz", 32'h005a5a00, {8'h0, c1_off});
        end_sim;
    end
endmodule : tb_top
`default_nettype wire
